// file: shared/apr_cfg.svh
// constants for the parallel result port of the 12-bit converter
`ifndef APR_CFG_SVH
`define APR_CFG_SVH

// ----------------------------------------------------------------
// widths and field positions
// ----------------------------------------------------------------
`define APR_RESULT_W 12
`define APR_BYTE_W 8
`define APR_LOW_NIB_HI 3
`define APR_LOW_NIB_LO 0
`define APR_HIGH_NIB_HI 11
`define APR_HIGH_NIB_LO 8
`define APR_CFG_ACQ_BIT 5
`define APR_PAD_ZERO 4'h0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define APR_RESULT_RST 12'h000
`define APR_BYTE_RST 8'h00
`define APR_CFG_RST 8'h00

// ----------------------------------------------------------------
// default conversion timing, in conversion clock cycles; divider in core clock cycles
// ----------------------------------------------------------------
`define APR_CONV_CLKS 13
`define APR_ACQ_CLKS 3
`define APR_CLK_DIV 7
`define APR_CNT_W 8

// ----------------------------------------------------------------
// bus timing bounds (ns) and, for all but the two DO1 bounds, their cycle counts at the core clock
// ----------------------------------------------------------------
`define APR_CORE_CLK_NS 20
`define APR_T_TC_NS 60
`define APR_T_TR_NS 40
`define APR_T_DO_NS 50
`define APR_T_DO1_RISE_NS 50
`define APR_T_DO1_FALL_NS 80
`define APR_T_INT1_NS 50
`define APR_T_TC_CYC (`APR_T_TC_NS / `APR_CORE_CLK_NS)
`define APR_T_TR_CYC (`APR_T_TR_NS / `APR_CORE_CLK_NS)
`define APR_T_DO_CYC (`APR_T_DO_NS / `APR_CORE_CLK_NS)
`define APR_T_INT1_CYC (`APR_T_INT1_NS / `APR_CORE_CLK_NS)

`endif

// file: shared/apr_pkg.sv
// types shared by the parallel result port
package apr_pkg;

    // ----------------------------------------------------------------
    // host strobes as they arrive on the pins
    // ----------------------------------------------------------------
    typedef struct packed {
        logic chip_sel_n;
        logic read_n;
        logic write_n;
        logic upper_byte_select;
        logic conv_clk_pin;
    } apr_pins_s;

    // ----------------------------------------------------------------
    // converter sequence
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACQ_TIMED,
        ST_ACQ_EXT,
        ST_CONV
    } apr_state_e;

endpackage : apr_pkg

// file: rtl/apr_sync.sv
// two-flop synchroniser bank for asynchronous pin inputs
`timescale 1ns/10ps
`default_nettype none

module apr_sync #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // pins in, synchronised copy out
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    // ----------------------------------------------------------------
    // one two-stage chain per bit; stage one feeds only stage two
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            logic meta_reg;
            logic hold_reg;
            always_ff @(posedge core_clk_i) begin
                if (rst_i) begin
                    meta_reg <= 1'b1;
                    hold_reg <= 1'b1;
                end else begin
                    meta_reg <= async_i[gi];
                    hold_reg <= meta_reg;
                end
            end
            assign sync_o[gi] = hold_reg;
        end
    endgenerate

endmodule : apr_sync

`default_nettype wire

// file: rtl/apr_port.sv
// byte-wide result port with conversion sequencing of the 12-bit converter
//
// Functional notes
// - upper select high: four MSBs, else eight LSBs
// - low lines carry 3..0 or 11..8
// - read falling edge returns done flag high
// - chip select rising releases the data bus
// - read rising releases the data bus
// - read falling with select drives valid data
// - select change during read switches driven half
// - conversion time counted in conversion clock cycles
// - done flag low once result is ready
// - write rising latches config, starts acquisition/conversion
// - chip select high keeps outputs undriven
// - reads start only on read fall with select
`include "apr_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module apr_port #(
    parameter int unsigned CONV_CLKS = `APR_CONV_CLKS,
    parameter int unsigned ACQ_CLKS = `APR_ACQ_CLKS,
    parameter int unsigned CLK_DIV = `APR_CLK_DIV
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // host strobes and data pins
    input wire apr_pkg::apr_pins_s pins_i,
    input wire logic [`APR_BYTE_W-1:0] data_i,
    // converter side
    input wire logic [`APR_RESULT_W-1:0] sample_i,
    input wire logic ext_clk_mode_i,
    // data bus drive
    output logic [`APR_BYTE_W-1:0] data_o,
    output logic data_oe_n_o,
    // status
    output logic conv_done_n_o,
    output logic busy_o,
    output logic [`APR_BYTE_W-1:0] config_o
);

    localparam int unsigned SYNC_W = $bits(apr_pkg::apr_pins_s) + `APR_BYTE_W;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [SYNC_W-1:0] sync_bus;
    apr_pkg::apr_pins_s pins_sync;
    logic [`APR_BYTE_W-1:0] data_sync;

    apr_sync #(
        .W(SYNC_W)
    ) u_sync (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .async_i({pins_i, data_i}),
        .sync_o(sync_bus)
    );

    assign pins_sync = apr_pkg::apr_pins_s'(sync_bus[SYNC_W-1:`APR_BYTE_W]);
    assign data_sync = sync_bus[`APR_BYTE_W-1:0];

    // ----------------------------------------------------------------
    // edge detection on the synchronised strobes
    // ----------------------------------------------------------------
    apr_pkg::apr_pins_s pins_prev_reg;

    // previous sample, reset to all ones, the idle level of the active-low strobes
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pins_prev_reg <= '1;
        end else begin
            pins_prev_reg <= pins_sync;
        end
    end

    logic cs_low;
    logic rd_fall;
    logic rd_rise;
    logic wr_rise;
    logic cs_rise;
    logic clk_fall;

    assign cs_low = ~pins_sync.chip_sel_n;
    assign rd_fall = pins_prev_reg.read_n & ~pins_sync.read_n;
    assign rd_rise = ~pins_prev_reg.read_n & pins_sync.read_n;
    assign wr_rise = ~pins_prev_reg.write_n & pins_sync.write_n;
    assign cs_rise = ~pins_prev_reg.chip_sel_n & pins_sync.chip_sel_n;
    assign clk_fall = pins_prev_reg.conv_clk_pin & ~pins_sync.conv_clk_pin;

    // ----------------------------------------------------------------
    // conversion clock enable: internal divider or external pin
    // ----------------------------------------------------------------
    logic [`APR_CNT_W-1:0] div_reg;
    logic div_tick;
    logic conv_tick;

    // free-running divider; the tick is one core cycle wide
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            div_reg <= '0;
        end else if (div_reg == `APR_CNT_W'(CLK_DIV - 1)) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + `APR_CNT_W'(1);
        end
    end

    assign div_tick = (div_reg == `APR_CNT_W'(CLK_DIV - 1));
    // external clock acts on its falling edge, as the converter does
    assign conv_tick = ext_clk_mode_i ? clk_fall : div_tick;

    // ----------------------------------------------------------------
    // acquisition and conversion sequencer
    // ----------------------------------------------------------------
    apr_pkg::apr_state_e state_reg;
    apr_pkg::apr_state_e state_next;
    logic [`APR_CNT_W-1:0] cnt_reg;
    logic [`APR_CNT_W-1:0] cnt_next;
    logic conv_end;
    logic write_start;

    // writes only count while the chip is selected
    assign write_start = wr_rise & cs_low;

    // next state; writes during conversion are ignored, the host must hold them off
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        conv_end = 1'b0;
        case (state_reg)
            apr_pkg::ST_IDLE: begin
                if (write_start) begin
                    cnt_next = '0;
                    if (data_sync[`APR_CFG_ACQ_BIT]) begin
                        state_next = apr_pkg::ST_ACQ_EXT;
                    end else begin
                        state_next = apr_pkg::ST_ACQ_TIMED;
                    end
                end
            end
            apr_pkg::ST_ACQ_TIMED: begin
                if (conv_tick) begin
                    if (cnt_reg == `APR_CNT_W'(ACQ_CLKS - 1)) begin
                        cnt_next = '0;
                        state_next = apr_pkg::ST_CONV;
                    end else begin
                        cnt_next = cnt_reg + `APR_CNT_W'(1);
                    end
                end
            end
            apr_pkg::ST_ACQ_EXT: begin
                if (write_start) begin
                    cnt_next = '0;
                    state_next = apr_pkg::ST_CONV;
                end
            end
            apr_pkg::ST_CONV: begin
                // write strobes are not looked at here
                if (conv_tick) begin
                    if (cnt_reg == `APR_CNT_W'(CONV_CLKS - 1)) begin
                        cnt_next = '0;
                        conv_end = 1'b1;
                        state_next = apr_pkg::ST_IDLE;
                    end else begin
                        cnt_next = cnt_reg + `APR_CNT_W'(1);
                    end
                end
            end
            default: begin
                state_next = apr_pkg::ST_IDLE;
                cnt_next = '0;
            end
        endcase
    end

    // sequencer state
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_reg <= apr_pkg::ST_IDLE;
            cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // busy flag mirrors any non-idle state
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
        end else begin
            busy_o <= (state_next != apr_pkg::ST_IDLE);
        end
    end

    // configuration byte captured on the starting write
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            config_o <= `APR_CFG_RST;
        end else if (state_reg == apr_pkg::ST_IDLE && write_start) begin
            config_o <= data_sync;
        end
    end

    // ----------------------------------------------------------------
    // result latch and done flag
    // ----------------------------------------------------------------
    logic [`APR_RESULT_W-1:0] result_reg;

    // result held until the next conversion ends
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            result_reg <= `APR_RESULT_RST;
        end else if (conv_end) begin
            result_reg <= sample_i;
        end
    end

    // done flag: a finishing conversion wins over a clearing read
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            conv_done_n_o <= 1'b1;
        end else if (conv_end) begin
            conv_done_n_o <= 1'b0;
        end else if (rd_fall) begin
            conv_done_n_o <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // read window and data bus drive
    // ----------------------------------------------------------------
    logic read_active_reg;

    // a read opens only on a read fall seen with the chip selected
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            read_active_reg <= 1'b0;
        end else if (!cs_low || rd_rise || cs_rise) begin
            read_active_reg <= 1'b0;
        end else if (rd_fall) begin
            read_active_reg <= 1'b1;
        end
    end

    logic drive_next;
    logic [`APR_BYTE_W-1:0] byte_next;

    // drive only inside a read window and never while deselected
    assign drive_next = cs_low & ~pins_sync.read_n & (read_active_reg | rd_fall);

    // half selection follows the select pin every cycle of the read
    assign byte_next = pins_sync.upper_byte_select ?
        {`APR_PAD_ZERO, result_reg[`APR_HIGH_NIB_HI:`APR_HIGH_NIB_LO]} :
        result_reg[`APR_BYTE_W-1:0];

    // data lines and enable come straight from flops
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            data_o <= `APR_BYTE_RST;
            data_oe_n_o <= 1'b1;
        end else begin
            data_o <= byte_next;
            data_oe_n_o <= ~drive_next;
        end
    end

endmodule : apr_port

`default_nettype wire

// file: verif/apr_port_chk.sv
// assertion checker for the byte-wide result port
`include "apr_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module apr_port_chk #(
    parameter int unsigned CONV_CLKS = 13,
    parameter int unsigned ACQ_CLKS = 3,
    parameter int unsigned CLK_DIV = 7
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // host pins and converter side
    input wire apr_pkg::apr_pins_s pins_i,
    input wire logic [`APR_BYTE_W-1:0] data_i,
    input wire logic [`APR_RESULT_W-1:0] sample_i,
    input wire logic ext_clk_mode_i,
    // device outputs
    input wire logic [`APR_BYTE_W-1:0] data_o,
    input wire logic data_oe_n_o,
    input wire logic conv_done_n_o,
    input wire logic busy_o,
    input wire logic [`APR_BYTE_W-1:0] config_o
);
    // ----------------------------------------------------------------
    // window for a timed conversion; divider phase at start is unknown
    // ----------------------------------------------------------------
    localparam int CONV_LO = (ACQ_CLKS + CONV_CLKS - 1) * CLK_DIV;
    localparam int CONV_HI = (ACQ_CLKS + CONV_CLKS + 1) * CLK_DIV + 2;
    wire logic cs_n = pins_i.chip_sel_n;
    wire logic rd_n = pins_i.read_n;
    wire logic wr_n = pins_i.write_n;
    wire logic hb = pins_i.upper_byte_select;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    // ----------------------------------------------------------------
    // bus drive, release and status relations
    // ----------------------------------------------------------------
    a_lo_byte: assert property ((!hb)[*5] ##0 !data_oe_n_o |-> data_o == sample_i[7:0])
        else $error("low half not on the bus");
    a_hi_nibble: assert property (hb[*5] ##0 !data_oe_n_o |-> data_o == {4'h0, sample_i[11:8]})
        else $error("high nibble not on the low lines");
    a_rd_drive: assert property ($fell(rd_n) && !cs_n ##1 (!rd_n && !cs_n)[*4] |-> !data_oe_n_o)
        else $error("read did not drive the bus");
    a_rd_release: assert property ($rose(rd_n) |-> ##[1:4] data_oe_n_o)
        else $error("bus still driven after read end");
    a_cs_release: assert property ($rose(cs_n) |-> ##[1:4] data_oe_n_o)
        else $error("bus still driven after deselect");
    a_cs_quiet: assert property (cs_n[*4] |-> data_oe_n_o)
        else $error("bus driven while deselected");
    a_done_clear: assert property ($fell(rd_n) && !conv_done_n_o |-> ##[1:4] conv_done_n_o)
        else $error("done flag not cleared by read");
    a_done_set: assert property ($fell(busy_o) |-> !conv_done_n_o)
        else $error("done flag not set at conversion end");
    a_write_start: assert property ($rose(wr_n) && !cs_n && !busy_o && !data_i[5] ##1 (wr_n && !cs_n)[*4]
        |-> busy_o && config_o == data_i)
        else $error("write did not latch and start");
    a_conv_len: assert property ($rose(busy_o) && !config_o[5] && !ext_clk_mode_i
        |-> ##[CONV_LO:CONV_HI] $fell(busy_o))
        else $error("conversion length out of window");

    c_done: cover property ($fell(conv_done_n_o));
    c_hi_read: cover property (!data_oe_n_o && hb);
    c_ext_acq: cover property ($rose(busy_o) && config_o[5]);
    c_ext_clk: cover property ($rose(busy_o) && ext_clk_mode_i);
endmodule : apr_port_chk

bind apr_port apr_port_chk #(.CONV_CLKS(CONV_CLKS), .ACQ_CLKS(ACQ_CLKS), .CLK_DIV(CLK_DIV)) apr_port_chk_inst (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .pins_i(pins_i), .data_i(data_i), .sample_i(sample_i),
    .ext_clk_mode_i(ext_clk_mode_i), .data_o(data_o), .data_oe_n_o(data_oe_n_o),
    .conv_done_n_o(conv_done_n_o), .busy_o(busy_o), .config_o(config_o));
`default_nettype wire

// file: verif/apr_host.sv
// host model driving the converter's parallel strobes
`include "apr_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module apr_host (
    // clock
    input wire logic core_clk_i,
    // bus as seen on the wire
    input wire logic [`APR_BYTE_W-1:0] bus_i,
    input wire logic bus_oe_n_i,
    // strobes and write data
    output var apr_pkg::apr_pins_s pins_o,
    output var logic [`APR_BYTE_W-1:0] data_o
);
    // ----------------------------------------------------------------
    // bus cycles; every change lands just after a rising edge
    // ----------------------------------------------------------------
    initial begin
        pins_o = 5'h1C;
        data_o = 8'h00;
    end

    task step(input int n);
        repeat (n) @(posedge core_clk_i);
        #2;
    endtask : step

    // select is set well ahead of the strobe so the synchroniser sees order
    task wr(input logic [7:0] cfg);
        step(1);
        pins_o.chip_sel_n = 1'b0;
        data_o = cfg;
        step(4);
        pins_o.write_n = 1'b0;
        step(4);
        pins_o.write_n = 1'b1;
        step(5);
        pins_o.chip_sel_n = 1'b1;
        data_o = ~cfg; // released data never keeps its last value
        step(4);
    endtask : wr

    // conversion clock pulses; the pin rests low between bursts
    task tick(input int n);
        repeat (n) begin
            pins_o.conv_clk_pin = 1'b1;
            step(3);
            pins_o.conv_clk_pin = 1'b0;
            step(3);
        end
    endtask : tick

    // reads the low half, then flips the half select within the same read
    task rd(input logic sel, output logic seen, output logic [7:0] lo, output logic [7:0] hi);
        seen = 1'b0;
        step(1);
        pins_o.chip_sel_n = !sel;
        step(4);
        pins_o.read_n = 1'b0;
        for (int k = 0; k < 8; k++) begin
            step(1);
            if (bus_oe_n_i === 1'b0) seen = 1'b1;
        end
        lo = bus_i;
        pins_o.upper_byte_select = 1'b1;
        step(5);
        hi = bus_i;
        pins_o.upper_byte_select = 1'b0;
        step(5);
        pins_o.read_n = 1'b1;
        step(4);
        pins_o.chip_sel_n = 1'b1;
        step(4);
    endtask : rd
endmodule : apr_host
`default_nettype wire

// file: verif/adc_parallel_result_port_bench.sv
// self-checking bench for the byte-wide result port
`timescale 1ns/10ps
`default_nettype none

module adc_parallel_result_port_bench;
    logic core_clk_i;
    logic rst_i;
    logic [11:0] sample;
    logic [7:0] host_data, dev_data, cfg_out, bus, lo, hi, cfg;
    logic oe_n, done_n, busy, seen, ext_mode;
    localparam int CONV = 12;
    localparam int ACQ = 2;
    localparam int DIV = 4;
    apr_pkg::apr_pins_s pins;
    int fails, n_tests;

    // released bus shows the inverse, so a stale value cannot pass
    assign bus = oe_n ? ~dev_data : dev_data;

    apr_port #(.CONV_CLKS(CONV), .ACQ_CLKS(ACQ), .CLK_DIV(DIV)) apr_port_inst (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .pins_i(pins), .data_i(host_data), .sample_i(sample),
        .ext_clk_mode_i(ext_mode), .data_o(dev_data), .data_oe_n_o(oe_n), .conv_done_n_o(done_n),
        .busy_o(busy), .config_o(cfg_out));
    apr_host apr_host_inst (.core_clk_i(core_clk_i), .bus_i(bus), .bus_oe_n_i(oe_n), .pins_o(pins),
        .data_o(host_data));

    // ----------------------------------------------------------------
    // clock, checking and closing
    // ----------------------------------------------------------------
    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end

    task chk(input logic [11:0] seen_v, input logic [11:0] exp_v);
        n_tests++;
        if (seen_v !== exp_v) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen_v, exp_v);
        end
    endtask : chk

    function logic [7:0] half(input logic [11:0] s, input logic up);
        return up ? {4'h0, s[11:8]} : s[7:0];
    endfunction : half

    task wait_done();
        for (int k = 0; k < 200 && done_n !== 1'b0; k++) @(posedge core_clk_i);
        #2;
    endtask : wait_done

    task results();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results

    // whole run is about a thousand cycles; ten thousand means a hang
    initial begin
        #200000;
        fails++;
        results();
    end

    // ----------------------------------------------------------------
    // main sequence: timed, refused and two-write conversions
    // ----------------------------------------------------------------
    initial begin
        fails = 0;
        n_tests = 0;
        rst_i = 1'b1;
        ext_mode = 1'b0;
        sample = 12'h000;
        void'($urandom(23));
        repeat (16) @(posedge core_clk_i);
        #2;
        rst_i = 1'b0;
        chk(12'({oe_n, done_n, busy}), 12'h006);
        chk(12'(cfg_out), 12'h000);
        for (int i = 0; i < 6; i++) begin
            ext_mode = (i == 3);
            sample = (i == 5) ? 12'hFFF : 12'($urandom);
            cfg = 8'($urandom);
            cfg[5] = (i == 2);
            apr_host_inst.wr(cfg);
            chk(12'(cfg_out), 12'(cfg));
            // the refused write waits until the timed acquisition is over and the conversion has begun
            if (i == 1) begin
                repeat (8) @(posedge core_clk_i);
                #2;
                apr_host_inst.wr(cfg ^ 8'hC3);
            end
            if (i == 2) begin
                repeat (20) @(posedge core_clk_i);
                #2;
                chk(12'(done_n), 12'h001);
                apr_host_inst.wr(cfg);
            end
            chk(12'(cfg_out), 12'(cfg));
            // external clock: one fall short must leave the result pending
            if (ext_mode) begin
                apr_host_inst.tick(ACQ + CONV - 1);
                chk(12'(done_n), 12'h001);
                apr_host_inst.tick(1);
                chk(12'(done_n), 12'h000);
            end
            wait_done();
            chk(12'({done_n, busy}), 12'h000);
            if (i == 0) begin
                apr_host_inst.rd(1'b0, seen, lo, hi);
                chk(12'({seen, done_n}), 12'h001);
            end
            apr_host_inst.rd(1'b1, seen, lo, hi);
            chk(12'(seen), 12'h001);
            chk(12'(lo), 12'(half(sample, 1'b0)));
            chk(12'(hi), 12'(half(sample, 1'b1)));
            chk(12'({done_n, oe_n}), 12'h003);
        end
        results();
    end
endmodule : adc_parallel_result_port_bench
`default_nettype wire
